// *** design/pac_align_ctrl.sv ***
// Alignment and pairing control of a six-channel PWM, with APB registers.
// Assumes prescaler ticks, enables, polarity, clock selects, period, duty
// and counter write strobes come from pclk-domain logic beside this block.
`timescale 1ns/1ps

// What this block does
// - Bits 5..0 pick per channel: 0 left aligned, 1 center aligned.
// - Control bits 6, 5, 4 pair channels 4/5, 2/3, 0/1 into 16 bits.
// - In a pair the even channel is the high byte, odd the low byte.
// - A paired channel drives only the odd channel's output pin.
// - The odd channel's clock, polarity, enable and alignment govern a pair.
// - Wait stop bit 3 halts the prescaler clock while in wait mode.
// - Freeze stop bit 2 halts the prescaler clock, and counters, in freeze.
// - Registers stay accessible; clock resumes when bit clears or freeze ends.
// - Left counts 0 to period-1; center counts up to period and down.
// - Writing either byte of a paired counter resets the whole 16-bit count.
module pac_align_ctrl
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Mode pins, asynchronous
    input wire logic wait_mode,
    input wire logic freeze_mode,
    // Prescaler ticks: clock A, SA, B, SB
    input wire logic tick_a,
    input wire logic tick_sa,
    input wire logic tick_b,
    input wire logic tick_sb,
    // Per-channel settings from the neighbouring registers
    input wire logic [5:0] channel_enable_bit,
    input wire logic [5:0] channel_polarity_bit,
    input wire logic [5:0] channel_clock_select_bit,
    input wire logic [47:0] channel_period_value,
    input wire logic [47:0] channel_duty_value,
    input wire logic [5:0] counter_write,
    // Results
    output logic [5:0] waveform_output_port,
    output logic [47:0] channel_counter,
    output logic [5:0] center_align_bit,
    output logic [2:0] pair_enable,
    output logic prescaler_run
);
    logic [7:0] align_reg;
    logic [7:0] align_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [5:0] wave_reg;
    logic [5:0] wave_next;
    logic [47:0] cnt_out_reg;
    logic [47:0] cnt_out_next;

    logic setup;
    logic access;
    logic hit_align;
    logic hit_ctrl;
    logic [2:0] paired;
    logic run;
    logic [15:0] eng_count [6];
    logic [5:0] eng_wave;

    assign setup = psel && !penable;
    assign access = psel && penable && pready_reg;
    assign hit_align = (paddr == pac_pkg::ALIGN_ADDR);
    assign hit_ctrl = (paddr == pac_pkg::CTRL_ADDR);
    assign paired = {ctrl_reg[pac_pkg::PAIR45_POS], ctrl_reg[pac_pkg::PAIR23_POS],
                     ctrl_reg[pac_pkg::PAIR01_POS]};

    // Register file and bus answer, access with zero wait states
    always_comb
    begin
        align_next = align_reg;
        ctrl_next = ctrl_reg;
        prdata_next = prdata_reg;
        pready_next = setup;
        pslverr_next = setup && !(hit_align || hit_ctrl);
        if (setup)
        begin
            if (hit_align)
                prdata_next = {24'h00_0000, align_reg};
            else if (hit_ctrl)
                prdata_next = {24'h00_0000, ctrl_reg};
            else
                prdata_next = pac_pkg::RDATA_RESET;
        end
        // Writes honoured in freeze too, so software can lift the gating
        if (access && pwrite && hit_align)
            align_next = pwdata[7:0] & pac_pkg::ALIGN_MASK;
        if (access && pwrite && hit_ctrl)
            ctrl_next = pwdata[7:0] & pac_pkg::CTRL_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            align_reg <= pac_pkg::ALIGN_RESET;
            ctrl_reg <= pac_pkg::CTRL_RESET;
            prdata_reg <= pac_pkg::RDATA_RESET;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            align_reg <= align_next;
            ctrl_reg <= ctrl_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    pac_lowpower pac_lowpower_i
    (
        .pclk(pclk),
        .presetn(presetn),
        .wait_mode(wait_mode),
        .freeze_mode(freeze_mode),
        .wait_stop(ctrl_reg[pac_pkg::WAIT_STOP_POS]),
        .freeze_stop(ctrl_reg[pac_pkg::FREEZE_STOP_POS]),
        .prescaler_run(run)
    );

    genvar i;
    generate
        for (i = 0; i < pac_pkg::NUM_CH; i++)
        begin : g_ch
            localparam int P = i / 2;
            logic base_tick;
            logic scaled_tick;
            logic tick;
            logic en;
            logic clr;
            logic [15:0] per;
            logic [15:0] dty;

            // Channels 2 and 3 run from clock B, the rest from clock A
            assign base_tick = (P == 1) ? tick_b : tick_a;
            assign scaled_tick = (P == 1) ? tick_sb : tick_sa;
            // Gated prescaler stops every counter
            assign tick = run && (channel_clock_select_bit[i] ? scaled_tick : base_tick);

            if ((i % 2) == 1)
            begin : g_odd
                // Odd channel owns the pair; even bytes on top
                assign per = paired[P] ? {channel_period_value[8*i-1 -: 8],
                                          channel_period_value[8*i+7 -: 8]}
                                       : {8'h00, channel_period_value[8*i+7 -: 8]};
                assign dty = paired[P] ? {channel_duty_value[8*i-1 -: 8],
                                          channel_duty_value[8*i+7 -: 8]}
                                       : {8'h00, channel_duty_value[8*i+7 -: 8]};
                assign en = channel_enable_bit[i];
                assign clr = counter_write[i] || (paired[P] && counter_write[i-1]);
            end
            else
            begin : g_even
                // Idle and cleared while its pair partner runs 16 bits
                assign per = {8'h00, channel_period_value[8*i+7 -: 8]};
                assign dty = {8'h00, channel_duty_value[8*i+7 -: 8]};
                assign en = channel_enable_bit[i] && !paired[P];
                assign clr = counter_write[i] || paired[P];
            end

            pac_chan_counter pac_chan_counter_i
            (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick),
                .enable(en),
                .center(align_reg[i]),
                .polarity(channel_polarity_bit[i]),
                .clear(clr),
                .period(per),
                .duty(dty),
                .count(eng_count[i]),
                .wave(eng_wave[i])
            );
        end
    endgenerate

    // Output staging so every pin leaves from a flop
    always_comb
    begin
        wave_next = eng_wave;
        cnt_out_next = cnt_out_reg;
        for (int k = 0; k < pac_pkg::NUM_CH; k++)
        begin
            if ((k % 2) == 0 && paired[k/2])
            begin
                wave_next[k] = 1'b0;
                cnt_out_next[8*k +: 8] = eng_count[k+1][15:8];
            end
            else
                cnt_out_next[8*k +: 8] = eng_count[k][7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wave_reg <= 6'b00_0000;
            cnt_out_reg <= 48'h0000_0000_0000;
        end
        else
        begin
            wave_reg <= wave_next;
            cnt_out_reg <= cnt_out_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign waveform_output_port = wave_reg;
    assign channel_counter = cnt_out_reg;
    assign center_align_bit = align_reg[5:0];
    assign pair_enable = paired;
    assign prescaler_run = run;

    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> (pready && !(penable && psel && pready && $past(pready))))
        else $error("setup cycle not answered in the next cycle");

    align_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && hit_align)
        |=> (align_reg == ($past(pwdata[7:0]) & pac_pkg::ALIGN_MASK)))
        else $error("alignment register did not take the written value");

    rsvd_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && (hit_align || hit_ctrl))
        |=> (prdata[31:7] == 25'h000_0000 && (!$past(hit_align) || !prdata[6])
             && (!$past(hit_ctrl) || prdata[1:0] == 2'b00)))
        else $error("reserved bits did not read as zero");

    pair_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        paired[2] |=> !waveform_output_port[4])
        else $error("paired even pin was driven");

    pair_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        paired[0] |=> (channel_counter[7:0] == $past(eng_count[1][15:8])))
        else $error("paired high byte did not come from the 16-bit count");

    pair_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (paired[1] && counter_write[2]) |=> ##1 (channel_counter[31:16] == 16'h0000))
        else $error("high byte write did not reset the paired counter");

    freeze_access_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!prescaler_run && setup && hit_ctrl) |=> (pready && !pslverr))
        else $error("register access refused while gated");

    align_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && hit_align) |=> (center_align_bit == $past(pwdata[5:0])))
        else $error("alignment bits not mirrored after a write");

    pair_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && hit_ctrl) |=> (pair_enable == $past(pwdata[6:4])))
        else $error("pairing bits did not follow the control write");

    ctrl_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && hit_ctrl) |=> (ctrl_reg[7] == 1'b0 && ctrl_reg[1:0] == 2'b00))
        else $error("reserved control bits took a written one");

    pair_pin0_a: assert property (@(posedge pclk) disable iff (!presetn)
        paired[0] |=> !waveform_output_port[0])
        else $error("paired even pin 0 was driven");

    // Odd enable alone decides the pair pin, even enable is ignored
    odd_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
        (paired[0] && !channel_enable_bit[1]) |=> ##1 !waveform_output_port[1])
        else $error("pair pin driven with odd channel disabled");

    // Unpaired counters 0 and 2 must hold still while the prescaler is gated
    gate_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!run && counter_write == 6'h00 && paired == 3'b000)
        |=> ({eng_count[0], eng_count[2]} == $past({eng_count[0], eng_count[2]})))
        else $error("channel counter moved while prescaler gated");

    pair23_cover: cover property (@(posedge pclk) disable iff (!presetn)
        paired[1] && counter_write[2]);

    align_cover: cover property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_align && pwdata[0]);

    pair_cover: cover property (@(posedge pclk) disable iff (!presetn)
        paired[2] && channel_enable_bit[5] && eng_count[5] > 16'h00ff);

endmodule

// *** design/pac_pkg.sv ***
// Constants and types for the PWM alignment and pairing control slice.
// Assumes a 32-bit APB slave on pclk; registers sit one per aligned word.
package pac_pkg;

    localparam int NUM_CH = 6;
    localparam int NUM_PAIRS = 3;

    // Register indices; byte address is four times the index
    localparam logic [7:0] ALIGN_IDX = 8'h04;
    localparam logic [7:0] CTRL_IDX = 8'h05;
    localparam logic [7:0] ALIGN_ADDR = {ALIGN_IDX[5:0], 2'b00};
    localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};

    // Field positions in the control register
    localparam int PAIR01_POS = 4;
    localparam int PAIR23_POS = 5;
    localparam int PAIR45_POS = 6;
    localparam int WAIT_STOP_POS = 3;
    localparam int FREEZE_STOP_POS = 2;

    // Writable bits; the rest read as zero
    localparam logic [7:0] ALIGN_MASK = 8'h3f;
    localparam logic [7:0] CTRL_MASK = 8'h7c;

    // Values after reset
    localparam logic [7:0] ALIGN_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic
    {
        PAC_DIR_UP = 1'b0,
        PAC_DIR_DOWN = 1'b1
    } pac_dir_t;

endpackage

// *** design/pac_chan_counter.sv ***
// One channel counter and waveform comparator, up to 16 bits wide.
// Assumes period and duty arrive already widened; tick is a pclk-domain pulse.
`timescale 1ns/1ps
module pac_chan_counter
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic tick,
    input wire logic enable,
    input wire logic center,
    input wire logic polarity,
    input wire logic clear,
    // Values
    input wire logic [15:0] period,
    input wire logic [15:0] duty,
    output logic [15:0] count,
    output logic wave
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    pac_pkg::pac_dir_t dir_reg;
    pac_pkg::pac_dir_t dir_next;
    logic wave_reg;
    logic wave_next;
    logic below_duty;

    always_comb
    begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        below_duty = (cnt_reg < duty);
        if (clear)
        begin
            // Counter write restarts the period counting up
            cnt_next = pac_pkg::CNT_RESET;
            dir_next = pac_pkg::PAC_DIR_UP;
        end
        else if (enable && tick)
        begin
            if (!center)
            begin
                // Left aligned: 0 .. period-1
                if (period == 16'h0000 || cnt_reg >= period - 16'h0001)
                    cnt_next = pac_pkg::CNT_RESET;
                else
                    cnt_next = cnt_reg + 16'h0001;
            end
            else if (dir_reg == pac_pkg::PAC_DIR_UP)
            begin
                // Center aligned: up to period, then back to 0
                if (cnt_reg >= period)
                begin
                    dir_next = pac_pkg::PAC_DIR_DOWN;
                    cnt_next = (period == 16'h0000) ? 16'h0000 : cnt_reg - 16'h0001;
                end
                else
                    cnt_next = cnt_reg + 16'h0001;
            end
            else if (cnt_reg == 16'h0000)
            begin
                dir_next = pac_pkg::PAC_DIR_UP;
                cnt_next = (period == 16'h0000) ? 16'h0000 : 16'h0001;
            end
            else
                cnt_next = cnt_reg - 16'h0001;
        end
        wave_next = enable && (polarity ? below_duty : !below_duty);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 16'h0000;
            dir_reg <= pac_pkg::PAC_DIR_UP;
            wave_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
            wave_reg <= wave_next;
        end
    end

    assign count = cnt_reg;
    assign wave = wave_reg;

    left_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && enable && !center && !clear && period != 16'h0000
         && cnt_reg == period - 16'h0001) |=> (cnt_reg == 16'h0000))
        else $error("left aligned counter did not wrap at period minus one");

    center_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && enable && center && !clear && period > 16'h0001
         && dir_reg == pac_pkg::PAC_DIR_UP && cnt_reg == period)
        |=> (dir_reg == pac_pkg::PAC_DIR_DOWN && cnt_reg == $past(period) - 16'h0001))
        else $error("center aligned counter did not turn down at period");

    counter_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        clear |=> (cnt_reg == 16'h0000 && dir_reg == pac_pkg::PAC_DIR_UP))
        else $error("counter write did not restart the counter");

endmodule

// *** design/pac_lowpower.sv ***
// Wait and freeze gating of the prescaler input clock.
// Assumes wait and freeze mode levels come from another domain.
`timescale 1ns/1ps
module pac_lowpower
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Mode pins, asynchronous
    input wire logic wait_mode,
    input wire logic freeze_mode,
    // Control bits
    input wire logic wait_stop,
    input wire logic freeze_stop,
    // Result
    output logic prescaler_run
);
    logic [1:0] wait_sync_reg;
    logic [1:0] wait_sync_next;
    logic [1:0] frz_sync_reg;
    logic [1:0] frz_sync_next;
    logic run_reg;
    logic run_next;

    always_comb
    begin
        wait_sync_next = {wait_sync_reg[0], wait_mode};
        frz_sync_next = {frz_sync_reg[0], freeze_mode};
        // Only the second stage is looked at
        run_next = !((wait_stop && wait_sync_reg[1])
                     || (freeze_stop && frz_sync_reg[1]));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_sync_reg <= 2'b00;
            frz_sync_reg <= 2'b00;
            run_reg <= 1'b1;
        end
        else
        begin
            wait_sync_reg <= wait_sync_next;
            frz_sync_reg <= frz_sync_next;
            run_reg <= run_next;
        end
    end

    assign prescaler_run = run_reg;

    wait_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wait_stop && wait_sync_reg[1]) |=> !prescaler_run)
        else $error("prescaler clock ran in wait with wait stop set");

    freeze_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (freeze_stop && frz_sync_reg[1]) |=> !prescaler_run)
        else $error("prescaler clock ran in freeze with freeze stop set");

    freeze_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!(freeze_stop && frz_sync_reg[1]) && !(wait_stop && wait_sync_reg[1]))
        |=> prescaler_run)
        else $error("prescaler clock did not resume");

    freeze_stop_cover: cover property (@(posedge pclk) disable iff (!presetn)
        (freeze_stop && frz_sync_reg[1]) ##1 !freeze_stop ##1 prescaler_run);

endmodule

// *** test/pac_pin_load.sv ***
// Load model on the six waveform pins: remembers which pins went high.
// Assumes the pins are registered in the pclk domain.
`timescale 1ns/1ps
module pac_pin_load
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins and control
    input wire logic [5:0] pins,
    input wire logic clr,
    output logic [5:0] seen_high
);
    logic [5:0] seen_reg;
    logic [5:0] seen_next;

    // Sticky, so a one-cycle glitch on a held pin is not missed
    always_comb
    begin
        seen_next = clr ? 6'h00 : (seen_reg | pins);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seen_reg <= 6'h00;
        else
            seen_reg <= seen_next;
    end

    assign seen_high = seen_reg;
endmodule

// *** test/pac_align_ctrl_tb.sv ***
// Self-checking bench for the alignment and pairing control slice.
// Assumes the package, the design and the pin load model compile first.
`timescale 1ns/1ps
module pac_align_ctrl_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, lfsr;
    logic wait_mode, freeze_mode, prescaler_run, pin_clr;
    logic [3:0] ticks;
    logic [5:0] en, pol, csel, cwr, pins, cab, seen_high;
    logic [47:0] per, duty, cnt;
    logic [2:0] pair_enable;
    logic [33:0] notes[$];
    int err_total, total_checks;

    pac_align_ctrl pac_align_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode),
        .freeze_mode(freeze_mode), .tick_a(ticks[0]), .tick_sa(ticks[1]),
        .tick_b(ticks[2]), .tick_sb(ticks[3]), .channel_enable_bit(en),
        .channel_polarity_bit(pol), .channel_clock_select_bit(csel),
        .channel_period_value(per), .channel_duty_value(duty), .counter_write(cwr),
        .waveform_output_port(pins), .channel_counter(cnt), .center_align_bit(cab),
        .pair_enable(pair_enable), .prescaler_run(prescaler_run));

    pac_pin_load pac_pin_load_i (.pclk(pclk), .presetn(presetn), .pins(pins),
        .clr(pin_clr), .seen_high(seen_high));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic complete_run();
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Note carries {is_read, slave_error, read_data}
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [32:0] exp);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        notes.push_back({~wr, exp});
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tick(logic [3:0] m, int n);
        repeat (n)
        begin
            @(posedge pclk);
            ticks <= m;
            @(posedge pclk);
            ticks <= 4'h0;
        end
        repeat (3) @(posedge pclk);
    endtask

    task automatic clr(logic [5:0] m);
        @(posedge pclk);
        cwr <= m;
        @(posedge pclk);
        cwr <= 6'h00;
        repeat (2) @(posedge pclk);
    endtask

    // Mode pins are synchronised; four edges cover the two-stage sync
    task automatic lp(logic [7:0] c, logic w, logic f, logic exp);
        apb(1'b1, pac_pkg::CTRL_ADDR, {24'h00_0000, c}, 33'h0_0000_0000);
        @(posedge pclk);
        wait_mode <= w;
        freeze_mode <= f;
        repeat (4) @(posedge pclk);
        check("prescaler_run", {47'h0, prescaler_run}, {47'h0, exp});
    endtask

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    always @(posedge pclk)
    begin
        logic [33:0] n;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            n = notes.pop_front();
            check("pslverr", {47'h0, pslverr}, {47'h0, n[32]});
            if (n[33])
                check("prdata", {16'h0000, prdata}, {16'h0000, n[31:0]});
        end
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        complete_run();
    end

    initial
    begin
        logic [7:0] v;
        err_total = 0;
        total_checks = 0;
        lfsr = 32'h0001_362a;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {wait_mode, freeze_mode, ticks, en, pol, csel, cwr, per, duty, pin_clr} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("run after reset", {47'h0, prescaler_run}, 48'h0000_0000_0001);
        apb(1'b0, pac_pkg::ALIGN_ADDR, 32'h0000_0000, 33'h0_0000_0000);
        apb(1'b0, pac_pkg::CTRL_ADDR, 32'h0000_0000, 33'h0_0000_0000);
        // Channels stay disabled while alignment and pairing move
        for (int i = 0; i < 12; i++)
        begin
            lfsr = lfsr_next(lfsr);
            v = lfsr[7:0] & pac_pkg::ALIGN_MASK;
            apb(1'b1, pac_pkg::ALIGN_ADDR, lfsr, 33'h0_0000_0000);
            apb(1'b0, pac_pkg::ALIGN_ADDR, 32'h0000_0000, {25'h0, v});
            check("center_align_bit", {42'h0, cab}, {42'h0, v[5:0]});
            lfsr = lfsr_next(lfsr);
            v = lfsr[7:0] & pac_pkg::CTRL_MASK;
            apb(1'b1, pac_pkg::CTRL_ADDR, lfsr, 33'h0_0000_0000);
            apb(1'b0, pac_pkg::CTRL_ADDR, 32'h0000_0000, {25'h0, v});
            check("pair_enable", {45'h0, pair_enable}, {45'h0, v[6:4]});
        end
        apb(1'b1, 8'h18, 32'hffff_ffff, 33'h1_0000_0000);
        apb(1'b0, 8'h18, 32'h0000_0000, 33'h1_0000_0000);
        apb(1'b0, pac_pkg::CTRL_ADDR, 32'h0000_0000, {25'h0, v});
        lp(8'h00, 1'b1, 1'b0, 1'b1);
        lp(8'h08, 1'b1, 1'b0, 1'b0);
        lp(8'h08, 1'b0, 1'b0, 1'b1);
        lp(8'h04, 1'b0, 1'b1, 1'b0);
        apb(1'b0, pac_pkg::CTRL_ADDR, 32'h0000_0000, 33'h0_0000_0004);
        lp(8'h00, 1'b0, 1'b1, 1'b1);
        lp(8'h04, 1'b0, 1'b1, 1'b0);
        lp(8'h04, 1'b0, 1'b0, 1'b1);
        // Single channels: ch0 left on clock A, ch2 center on clock B
        lp(8'h00, 1'b0, 1'b0, 1'b1);
        apb(1'b1, pac_pkg::ALIGN_ADDR, 32'h0000_0004, 33'h0_0000_0000);
        per <= 48'h0000_0003_0005;
        en <= 6'h05;
        clr(6'h05);
        tick(4'h5, 9);
        check("ch0 left count", {40'h0, cnt[7:0]}, 48'h0000_0000_0004);
        check("ch2 center count", {40'h0, cnt[23:16]}, 48'h0000_0000_0003);
        check("ch1 idle count", {40'h0, cnt[15:8]}, 48'h0000_0000_0000);
        lp(8'h04, 1'b0, 1'b1, 1'b0);
        tick(4'h5, 5);
        check("frozen count", {40'h0, cnt[7:0]}, 48'h0000_0000_0004);
        lp(8'h00, 1'b0, 1'b0, 1'b1);
        // Pair 0/1: odd channel's clock, polarity, enable govern
        en <= 6'h00;
        apb(1'b1, pac_pkg::ALIGN_ADDR, 32'h0000_0000, 33'h0_0000_0000);
        apb(1'b1, pac_pkg::CTRL_ADDR, 32'h0000_0010, 33'h0_0000_0000);
        per <= 48'h0000_0000_0501;
        duty <= 48'h0000_0000_0001;
        pol <= 6'h02;
        csel <= 6'h02;
        en <= 6'h02;
        clr(6'h01);
        pin_clr <= 1'b1;
        @(posedge pclk);
        pin_clr <= 1'b0;
        tick(4'h2, 300);
        check("paired count", {32'h0, cnt[7:0], cnt[15:8]}, 48'h0000_0000_0027);
        check("paired pins", {42'h0, pins[1:0]}, 48'h0000_0000_0002);
        check("even pin load", {47'h0, seen_high[0]}, 48'h0000_0000_0000);
        tick(4'h1, 5);
        check("paired clock", {32'h0, cnt[7:0], cnt[15:8]}, 48'h0000_0000_0027);
        clr(6'h01);
        check("paired clear", {32'h0, cnt[7:0], cnt[15:8]}, 48'h0000_0000_0000);
        tick(4'h2, 3);
        clr(6'h02);
        check("low clear", {32'h0, cnt[7:0], cnt[15:8]}, 48'h0000_0000_0000);
        // Pair 2/3 on clock B, period 0x0100; high byte write clears all 16 bits
        en <= 6'h00;
        apb(1'b1, pac_pkg::CTRL_ADDR, 32'h0000_0020, 33'h0_0000_0000);
        per <= 48'h0000_0001_0501;
        csel <= 6'h00;
        en <= 6'h08;
        clr(6'h08);
        tick(4'h4, 4);
        check("pair23 count", {32'h0, cnt[23:16], cnt[31:24]}, 48'h0000_0000_0004);
        check("pair23 pins", {44'h0, pins[5:2]}, 48'h0000_0000_0002);
        clr(6'h04);
        check("high clear", {32'h0, cnt[23:16], cnt[31:24]}, 48'h0000_0000_0000);
        complete_run();
    end
endmodule
